// ---- logic/dsbb_correlator.sv ----
// Receive correlator: counts chip matches per bit and applies the two thresholds
`timescale 1ns/1ps
`default_nettype none
module dsbb_correlator #(
  parameter int CODE_W = 64
) (
  input wire logic i_clk, // Clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_srst, // Device soft reset
  input wire logic [CODE_W-1:0] i_code, // Spreading code
  input wire logic [1:0] i_mode, // Code length mode
  input wire logic [6:0] i_thr_low, // Low threshold
  input wire logic [6:0] i_thr_high, // High threshold
  input wire logic i_chip_en, // Received chip strobe
  input wire logic i_chip, // Received chip
  output logic o_bit_en, // Decided bit strobe
  output logic o_bit, // Decided bit value
  output logic o_bit_valid // Bit passed a threshold
);
  if (CODE_W != 64) begin : g_bad_width
    $error("dsbb_correlator: CODE_W must be 64");
  end
  logic [5:0] pos_q;
  logic [6:0] cnt_q;
  logic en_q;
  logic bit_q;
  logic vld_q;
  wire [5:0] first = (i_mode == 2'd2) ? 6'd32 : 6'd0;
  wire [5:0] last = (i_mode == 2'd1) ? 6'd31 : 6'd63;
  wire match = (i_chip == i_code[pos_q]);
  wire [6:0] cnt_n = cnt_q + {6'd0, match};
  wire is_one = (cnt_n >= i_thr_high);
  wire is_zero = (cnt_n <= i_thr_low);
  assign o_bit_en = en_q;
  assign o_bit = bit_q;
  assign o_bit_valid = vld_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pos_q <= 6'd0;
      cnt_q <= 7'd0;
      en_q <= 1'b0;
      bit_q <= 1'b0;
      vld_q <= 1'b0;
    end else if (i_srst) begin
      pos_q <= first;
      cnt_q <= 7'd0;
      en_q <= 1'b0;
    end else begin
      en_q <= 1'b0;
      if (i_chip_en) begin
        if (pos_q == last) begin
          pos_q <= first;
          cnt_q <= 7'd0;
          en_q <= 1'b1;
          bit_q <= is_one;
          vld_q <= is_one | is_zero;
        end else begin
          pos_q <= pos_q + 6'd1;
          cnt_q <= cnt_n;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/dsbb_pkg.sv ----
// Package: register map, field positions and reset values of the baseband control bank
package dsbb_pkg;
  localparam logic [5:0] ADDR_TX_VALID = 6'h10;
  localparam logic [5:0] ADDR_CODE_BASE = 6'h11;
  localparam logic [5:0] ADDR_CODE_LAST = 6'h18;
  localparam logic [5:0] ADDR_THR_LOW = 6'h19;
  localparam logic [5:0] ADDR_THR_HIGH = 6'h1a;
  localparam logic [5:0] ADDR_WAKE_EN = 6'h1c;
  localparam logic [5:0] ADDR_WAKE_STAT = 6'h1d;
  localparam logic [5:0] ADDR_ANALOG = 6'h20;
  localparam logic [5:0] ADDR_CHANNEL = 6'h21;
  localparam logic [5:0] ADDR_GAIN_CTL = 6'h2e;
  localparam logic [5:0] ADDR_CARRIER = 6'h2f;
  localparam logic [63:0] RST_CODE = 64'h1e8b6a3de0e9b222;
  localparam logic [6:0] RST_THR_LOW = 7'h08;
  localparam logic [6:0] RST_THR_HIGH = 7'h38;
  localparam logic RST_WAKE_EN = 1'b0;
  localparam logic RST_WAKE_STAT = 1'b1;
  localparam logic [7:0] RST_ANALOG = 8'h00;
  localparam logic [7:0] RST_CHANNEL = 8'h00;
  localparam logic [7:0] RST_OVR = 8'h00;
  localparam int ANA_RESET_BIT = 0;
  localparam int ANA_AMP_INV_BIT = 1;
  localparam int ANA_AMP_OE_BIT = 2;
  localparam int ANA_ID_RD_BIT = 5;
  localparam int ANA_GAIN_WE_BIT = 6;
  localparam int CHAN_COUNTER_SEL_BIT = 7;
  localparam logic [7:0] ANA_WR_MASK = 8'h67;
  localparam logic [7:0] OVR_WR_MASK = 8'h80;
  localparam int CHIPS_FULL = 64;
  localparam int CHIPS_HALF = 32;
  // Cycles per chip at the 100 MHz register clock
  localparam int CHIP_DIV = 8;
  localparam int READY_NS = 100;
  localparam int CLK_NS = 10;
  localparam int READY_CYC = (READY_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {DSBB_CODE_FULL, DSBB_CODE_LOW, DSBB_CODE_HIGH, DSBB_CODE_BOTH} dsbb_code_mode_t;
endpackage

// ---- logic/dsbb_regs.sv ----
// Baseband control register bank with spreader, correlator, wake and amp control
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - 64-bit code spreads bits, whole or as two 32-chip halves.
// - Chips leave in order bit 0 up to bit 63.
// - Each byte bit sends data when valid, preamble when not.
// - Serializer shifts LSB first and stops when no valid bits remain.
// - Seven-bit low threshold sets most matches allowed for a zero; reset 0x08.
// - Seven-bit high threshold sets matches needed for a one.
// - Wake enable bit zero gates the wakeup interrupt.
// - Wakeup event once power-down releases and device is ready.
// - Wake status sets on wakeup, clears on read, ignores writes.
// - Gain and carrier override writes work only with bit 6 set.
// - Amp control pin driven only while its output enable is one.
// - Amp invert bit one makes pin active low, zero active high.
// - Writing analog bit 0 resets all registers, then it self-clears.
// - Counter select one uses counters, zero uses channel field.
// - One signal strength sample captured on each receive entry.
module dsbb_regs #(
  parameter int CODE_W = 64
) (
  input wire logic i_clk, // Clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_wr, // Register write strobe
  input wire logic i_rd, // Register read strobe
  input wire logic [5:0] i_addr, // Register address
  input wire logic [7:0] i_wdata, // Write data
  output logic [7:0] o_rdata, // Read data
  input wire logic i_power_down_pin, // Power-down pin, high holds down
  input wire logic [1:0] i_code_mode, // Code length mode
  input wire logic i_tx_load, // Load tx byte pulse
  input wire logic [7:0] i_tx_data, // Tx byte
  output logic o_tx_busy, // Serializer busy
  output logic o_tx_chip, // Tx chip
  output logic o_tx_chip_en, // Tx chip strobe
  output logic o_tx_is_data, // Tx sends data
  input wire logic i_rx_chip_en, // Rx chip strobe
  input wire logic i_rx_chip, // Rx chip
  output logic o_rx_bit_en, // Rx bit strobe
  output logic o_rx_bit, // Rx bit
  output logic o_rx_bit_valid, // Rx bit valid
  input wire logic i_rx_enter, // Receive mode entry pulse
  input wire logic [4:0] i_rssi, // Live signal strength
  output logic [4:0] o_rssi_sample, // Captured strength
  output logic o_rssi_valid, // Sample taken
  input wire logic [7:0] i_synth_count, // Separate counter value
  output logic [7:0] o_synth_word, // Word used by synthesizer
  output logic o_synth_use_counter, // Counter path selected
  output logic o_wake_irq, // Wakeup interrupt request
  output logic o_amp_control_pin, // Amp control output
  output logic o_amp_control_oe, // Amp control output enable
  output logic o_id_read_enable, // ID block enable
  output logic [7:0] o_gain_override, // Gain control register
  output logic [7:0] o_carrier_override // Carrier override register
);
  if (CODE_W != 64) begin : g_bad_width
    $error("dsbb_regs: CODE_W must be 64");
  end
  logic [CODE_W-1:0] code_q;
  logic [7:0] txval_q;
  logic [6:0] thr_low_q;
  logic [6:0] thr_high_q;
  logic wake_en_q;
  logic wake_stat_q;
  logic [7:0] ana_q;
  logic [7:0] chan_q;
  logic [7:0] gain_q;
  logic [7:0] carr_q;
  logic [7:0] rdata_q;
  logic pd_q;
  logic [3:0] rdy_q;
  logic [4:0] rssi_q;
  logic rssi_v_q;
  logic srst_q;
  // soft reset from analog bit 0
  wire srst_d = i_wr && (i_addr == dsbb_pkg::ADDR_ANALOG) && i_wdata[dsbb_pkg::ANA_RESET_BIT];
  wire wr_ok = i_wr && !srst_q;
  wire in_code = (i_addr >= dsbb_pkg::ADDR_CODE_BASE) && (i_addr <= dsbb_pkg::ADDR_CODE_LAST);
  wire [2:0] code_byte = 3'(i_addr - dsbb_pkg::ADDR_CODE_BASE);
  wire rdy_done = (rdy_q == 4'(dsbb_pkg::READY_CYC));
  wire wake_evt = !pd_q && (rdy_q == 4'(dsbb_pkg::READY_CYC - 1));
  wire rd_wake = i_rd && (i_addr == dsbb_pkg::ADDR_WAKE_STAT);
  wire gain_we = ana_q[dsbb_pkg::ANA_GAIN_WE_BIT];
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_code
      // code bytes loaded one per address
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          code_q[8*g +: 8] <= dsbb_pkg::RST_CODE[8*g +: 8];
        end else if (srst_q) begin
          code_q[8*g +: 8] <= dsbb_pkg::RST_CODE[8*g +: 8];
        end else if (wr_ok && in_code && code_byte == 3'(g)) begin
          code_q[8*g +: 8] <= i_wdata;
        end
      end
    end
  endgenerate
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= srst_d;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      txval_q <= 8'h00;
      thr_low_q <= dsbb_pkg::RST_THR_LOW;
      thr_high_q <= dsbb_pkg::RST_THR_HIGH;
      wake_en_q <= dsbb_pkg::RST_WAKE_EN;
      chan_q <= dsbb_pkg::RST_CHANNEL;
    end else if (srst_q) begin
      txval_q <= 8'h00;
      thr_low_q <= dsbb_pkg::RST_THR_LOW;
      thr_high_q <= dsbb_pkg::RST_THR_HIGH;
      wake_en_q <= dsbb_pkg::RST_WAKE_EN;
      chan_q <= dsbb_pkg::RST_CHANNEL;
    end else if (wr_ok) begin
      if (i_addr == dsbb_pkg::ADDR_TX_VALID) txval_q <= i_wdata;
      if (i_addr == dsbb_pkg::ADDR_THR_LOW) thr_low_q <= i_wdata[6:0];
      if (i_addr == dsbb_pkg::ADDR_THR_HIGH) thr_high_q <= i_wdata[6:0];
      if (i_addr == dsbb_pkg::ADDR_WAKE_EN) wake_en_q <= i_wdata[0];
      if (i_addr == dsbb_pkg::ADDR_CHANNEL) chan_q <= i_wdata;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ana_q <= dsbb_pkg::RST_ANALOG;
      gain_q <= dsbb_pkg::RST_OVR;
      carr_q <= dsbb_pkg::RST_OVR;
    end else if (srst_q) begin
      ana_q <= dsbb_pkg::RST_ANALOG;
      gain_q <= dsbb_pkg::RST_OVR;
      carr_q <= dsbb_pkg::RST_OVR;
    end else if (wr_ok) begin
      if (i_addr == dsbb_pkg::ADDR_ANALOG) ana_q <= i_wdata & dsbb_pkg::ANA_WR_MASK & 8'hfe;
      if (i_addr == dsbb_pkg::ADDR_GAIN_CTL && gain_we) gain_q <= i_wdata & dsbb_pkg::OVR_WR_MASK;
      if (i_addr == dsbb_pkg::ADDR_CARRIER && gain_we) carr_q <= i_wdata & dsbb_pkg::OVR_WR_MASK;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pd_q <= 1'b1;
      rdy_q <= 4'd0;
    end else begin
      pd_q <= i_power_down_pin;
      if (pd_q) rdy_q <= 4'd0;
      else if (!rdy_done) rdy_q <= rdy_q + 4'd1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wake_stat_q <= dsbb_pkg::RST_WAKE_STAT;
    end else if (wake_evt) begin
      wake_stat_q <= 1'b1;
    end else if (srst_q) begin
      wake_stat_q <= dsbb_pkg::RST_WAKE_STAT;
    end else if (rd_wake) begin
      wake_stat_q <= 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rssi_q <= 5'd0;
      rssi_v_q <= 1'b0;
    end else if (srst_q) begin
      rssi_q <= 5'd0;
      rssi_v_q <= 1'b0;
    end else if (i_rx_enter) begin
      rssi_q <= i_rssi;
      rssi_v_q <= 1'b1;
    end
  end
  wire [7:0] rd_mux =
    in_code ? code_q[8*code_byte +: 8] :
    (i_addr == dsbb_pkg::ADDR_TX_VALID) ? txval_q :
    (i_addr == dsbb_pkg::ADDR_THR_LOW) ? {1'b0, thr_low_q} :
    (i_addr == dsbb_pkg::ADDR_THR_HIGH) ? {1'b0, thr_high_q} :
    (i_addr == dsbb_pkg::ADDR_WAKE_EN) ? {7'd0, wake_en_q} :
    (i_addr == dsbb_pkg::ADDR_WAKE_STAT) ? {7'd0, wake_stat_q} :
    (i_addr == dsbb_pkg::ADDR_ANALOG) ? ana_q :
    (i_addr == dsbb_pkg::ADDR_CHANNEL) ? chan_q :
    (i_addr == dsbb_pkg::ADDR_GAIN_CTL) ? gain_q :
    (i_addr == dsbb_pkg::ADDR_CARRIER) ? carr_q : 8'h00;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      rdata_q <= rd_mux;
    end
  end
  assign o_rdata = rdata_q;
  // interrupt gate, status kept while masked
  assign o_wake_irq = wake_stat_q & wake_en_q;
  assign o_amp_control_oe = ana_q[dsbb_pkg::ANA_AMP_OE_BIT];
  assign o_amp_control_pin = ana_q[dsbb_pkg::ANA_AMP_OE_BIT] & (o_tx_busy ^ ana_q[dsbb_pkg::ANA_AMP_INV_BIT]);
  assign o_id_read_enable = ana_q[dsbb_pkg::ANA_ID_RD_BIT];
  assign o_gain_override = gain_q;
  assign o_carrier_override = carr_q;
  assign o_rssi_sample = rssi_q;
  assign o_rssi_valid = rssi_v_q;
  assign o_synth_use_counter = chan_q[dsbb_pkg::CHAN_COUNTER_SEL_BIT];
  assign o_synth_word = o_synth_use_counter ? i_synth_count : {1'b0, chan_q[6:0]};
  dsbb_tx_spreader #(.CODE_W(CODE_W), .DIV(dsbb_pkg::CHIP_DIV)) u_tx (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_srst(srst_q),
    .i_code(code_q),
    .i_mode(i_code_mode),
    .i_load(i_tx_load),
    .i_data(i_tx_data),
    .i_valid(txval_q),
    .o_busy(o_tx_busy),
    .o_chip(o_tx_chip),
    .o_chip_en(o_tx_chip_en),
    .o_is_data(o_tx_is_data)
  );
  dsbb_correlator #(.CODE_W(CODE_W)) u_rx (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_srst(srst_q),
    .i_code(code_q),
    .i_mode(i_code_mode),
    .i_thr_low(thr_low_q),
    .i_thr_high(thr_high_q),
    .i_chip_en(i_rx_chip_en),
    .i_chip(i_rx_chip),
    .o_bit_en(o_rx_bit_en),
    .o_bit(o_rx_bit),
    .o_bit_valid(o_rx_bit_valid)
  );
endmodule
`default_nettype wire

// ---- logic/dsbb_tx_spreader.sv ----
// Transmit serializer: spreads each byte bit over the chips of the spreading code
`timescale 1ns/1ps
`default_nettype none
module dsbb_tx_spreader #(
  parameter int CODE_W = 64,
  parameter int DIV = 8
) (
  input wire logic i_clk, // Clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_srst, // Device soft reset
  input wire logic [CODE_W-1:0] i_code, // Spreading code
  input wire logic [1:0] i_mode, // Code length mode
  input wire logic i_load, // Load byte pulse
  input wire logic [7:0] i_data, // Byte to send
  input wire logic [7:0] i_valid, // Per-bit valid mask
  output logic o_busy, // Shifter holds valid bits
  output logic o_chip, // Chip on air
  output logic o_chip_en, // Chip strobe
  output logic o_is_data // Data, not preamble
);
  // Divider counter is 8 bits wide
  if (CODE_W != 64 || DIV < 1 || DIV > 256) begin : g_bad_param
    $error("dsbb_tx_spreader: unsupported parameters");
  end
  logic [7:0] dat_q;
  logic [7:0] val_q;
  logic [5:0] chip_q;
  logic [7:0] div_q;
  logic chip_q_out;
  logic en_q;
  logic isd_q;
  wire tick = (div_q == 8'(DIV - 1));
  wire [1:0] md = i_mode;
  wire [5:0] first = (md == 2'd2) ? 6'd32 : 6'd0;
  wire [5:0] last = (md == 2'd1) ? 6'd31 : 6'd63;
  wire [5:0] idx = chip_q;
  wire code_bit = i_code[idx];
  wire bit_end = (chip_q == last);
  assign o_busy = |val_q;
  assign o_chip = chip_q_out;
  assign o_chip_en = en_q;
  assign o_is_data = isd_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dat_q <= 8'h00;
      val_q <= 8'h00;
      chip_q <= 6'd0;
      div_q <= 8'h00;
      chip_q_out <= 1'b0;
      en_q <= 1'b0;
      isd_q <= 1'b0;
    end else if (i_srst) begin
      val_q <= 8'h00;
      en_q <= 1'b0;
      div_q <= 8'h00;
    end else if (i_load && !o_busy) begin
      dat_q <= i_data;
      val_q <= i_valid;
      chip_q <= first;
      div_q <= 8'h00;
    end else if (o_busy) begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      en_q <= tick;
      if (tick) begin
        isd_q <= val_q[0];
        chip_q_out <= val_q[0] ? (code_bit ^ ~dat_q[0]) : code_bit;
        chip_q <= bit_end ? first : chip_q + 6'd1;
        if (bit_end) begin
          dat_q <= {1'b0, dat_q[7:1]};
          val_q <= {1'b0, val_q[7:1]};
        end
      end
    end else begin
      en_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- test/dsbb_host_model.sv ----
// Host model: register writes and reads of the control bank
`timescale 1ns/1ps
`default_nettype none
module dsbb_host_model (
  input wire logic i_clk, // Clock
  input wire logic [7:0] i_rdata, // Read data
  output logic o_wr, // Write strobe
  output logic o_rd, // Read strobe
  output logic [5:0] o_addr, // Address
  output logic [7:0] o_wdata // Write data
);
  logic [7:0] ana_q = 8'h00;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 6'h00;
    o_wdata = 8'h00;
  end
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == dsbb_pkg::ADDR_ANALOG) v = d & dsbb_pkg::ANA_WR_MASK;
    // enable and invert changed in separate writes
    if (a == dsbb_pkg::ADDR_ANALOG && v[2] != ana_q[2] && v[1] != ana_q[1]) put(a, {v[7:2], ana_q[1], 1'b0});
    put(a, v);
    if (a == dsbb_pkg::ADDR_ANALOG) ana_q = v[0] ? 8'h00 : v;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ---- test/dsbb_regs_sva.sv ----
// Checker: port-level properties of the baseband control bank
`timescale 1ns/1ps
`default_nettype none
module dsbb_regs_sva #(
  parameter int CODE_W = 64
) (
  input wire logic i_clk, // Clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [5:0] i_addr, // Address
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_power_down_pin, // Power-down pin
  input wire logic i_rx_enter, // Receive entry pulse
  input wire logic [4:0] i_rssi, // Live strength
  input wire logic [7:0] i_synth_count, // Counter value
  input wire logic o_tx_busy, // Serializer busy
  input wire logic o_tx_chip_en, // Tx chip strobe
  input wire logic o_rx_bit_en, // Rx bit strobe
  input wire logic o_rx_bit, // Rx bit
  input wire logic o_rx_bit_valid, // Rx bit valid
  input wire logic [4:0] o_rssi_sample, // Captured strength
  input wire logic o_rssi_valid, // Sample taken
  input wire logic [7:0] o_synth_word, // Synth word
  input wire logic o_synth_use_counter, // Counter path
  input wire logic o_wake_irq, // Wake interrupt
  input wire logic o_amp_control_pin, // Amp pin
  input wire logic o_amp_control_oe, // Amp pin enable
  input wire logic [7:0] o_gain_override, // Gain override
  input wire logic [7:0] o_carrier_override // Carrier override
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire logic ana_rst = i_wr && i_addr == dsbb_pkg::ADDR_ANALOG && i_wdata[0];
  wire logic ovr_wr = i_wr && (i_addr == dsbb_pkg::ADDR_GAIN_CTL || i_addr == dsbb_pkg::ADDR_CARRIER);

  a_wake_masked: assert property (i_wr && i_addr == dsbb_pkg::ADDR_WAKE_EN && !i_wdata[0] |=> !o_wake_irq)
    else $error("wake interrupt raised while disabled");
  a_read_clears: assert property (i_rd && !i_wr && i_addr == dsbb_pkg::ADDR_WAKE_STAT && i_power_down_pin
    && $past(i_power_down_pin) && !$past(ana_rst) |=> !o_wake_irq)
    else $error("wake status not cleared by read");
  a_oe_write: assert property (i_wr && i_addr == dsbb_pkg::ADDR_ANALOG && !i_wdata[0] && !$past(ana_rst)
    |=> o_amp_control_oe == $past(i_wdata[2]))
    else $error("amp enable does not follow write");
  a_pin_off: assert property (!o_amp_control_oe |-> !o_amp_control_pin)
    else $error("amp pin active while disabled");
  a_pin_toggle: assert property (o_amp_control_oe && $stable(o_amp_control_oe) && $changed(o_tx_busy)
    |-> $changed(o_amp_control_pin))
    else $error("amp pin ignores transmit activity");
  a_soft_reset: assert property (ana_rst |=> ##1 !o_amp_control_oe && o_gain_override == 8'h00
    && !o_synth_use_counter)
    else $error("soft reset left registers set");
  a_ovr_source: assert property (($changed(o_gain_override) || $changed(o_carrier_override))
    |-> $past(ovr_wr) || $past(ana_rst, 2))
    else $error("override changed without write");
  a_synth_path: assert property (o_synth_word == (o_synth_use_counter ? i_synth_count
    : {1'b0, o_synth_word[6:0]}))
    else $error("synth word from wrong source");
  a_rssi_take: assert property (i_rx_enter |=> o_rssi_valid && o_rssi_sample == $past(i_rssi))
    else $error("strength sample not captured");
  a_chip_spacing: assert property (o_tx_chip_en |=> !o_tx_chip_en [*7])
    else $error("chip strobes too close");
  a_bit_valid: assert property (o_rx_bit_en && o_rx_bit |-> o_rx_bit_valid)
    else $error("one decided without valid");

  c_soft_reset: cover property (ana_rst);
  c_rx_bit: cover property (o_rx_bit_en && o_rx_bit_valid);
  c_wake_irq: cover property (o_wake_irq);
endmodule
bind dsbb_regs dsbb_regs_sva #(.CODE_W(CODE_W)) dsbb_regs_sva_i (.*);
`default_nettype wire

// ---- test/tb_dsbb_regs.sv ----
// Testbench: register, wake, amp, synth, tx and rx checks of the control bank
`timescale 1ns/1ps
`default_nettype none
module tb_dsbb_regs;
  localparam logic [63:0] CODE = dsbb_pkg::RST_CODE;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic wr, rd, pd, tx_load, tx_busy, tx_chip, tx_chip_en, tx_is_data, rx_chip_en, rx_chip;
  logic rx_bit_en, rx_bit, rx_valid, rx_enter, rssi_valid, use_cnt, irq, amp_pin, amp_oe, id_en;
  logic [1:0] mode;
  logic [4:0] rssi, rssi_sample;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, tx_data, synth_count, synth_word, gain, carrier, v;
  int fail_count = 0;
  int comparisons = 0;
  int n, b;
  int mt[6] = '{64, 56, 55, 32, 8, 0};
  logic [7:0] mx[6] = '{8'h03, 8'h03, 8'h00, 8'h00, 8'h02, 8'h02};

  always #5 i_clk = ~i_clk;

  dsbb_host_model dsbb_host_model_i (.i_clk(i_clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata));
  dsbb_regs dsbb_regs_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .i_power_down_pin(pd), .i_code_mode(mode), .i_tx_load(tx_load),
    .i_tx_data(tx_data), .o_tx_busy(tx_busy), .o_tx_chip(tx_chip), .o_tx_chip_en(tx_chip_en),
    .o_tx_is_data(tx_is_data), .i_rx_chip_en(rx_chip_en), .i_rx_chip(rx_chip), .o_rx_bit_en(rx_bit_en),
    .o_rx_bit(rx_bit), .o_rx_bit_valid(rx_valid), .i_rx_enter(rx_enter), .i_rssi(rssi),
    .o_rssi_sample(rssi_sample), .o_rssi_valid(rssi_valid), .i_synth_count(synth_count),
    .o_synth_word(synth_word), .o_synth_use_counter(use_cnt), .o_wake_irq(irq), .o_amp_control_pin(amp_pin),
    .o_amp_control_oe(amp_oe), .o_id_read_enable(id_en), .o_gain_override(gain), .o_carrier_override(carrier));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    dsbb_host_model_i.rd(a, v);
    chk8(v, exp);
  endtask
  task automatic test_done;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    {pd, tx_load, rx_chip_en, rx_chip, rx_enter, mode} = '0;
    {tx_data, synth_count, rssi} = '0;
    repeat (4) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (20) @(negedge i_clk);
    for (int k = 0; k < 8; k++) rdc(dsbb_pkg::ADDR_CODE_BASE + 6'(k), CODE[8*k +: 8]);
    rdc(dsbb_pkg::ADDR_THR_LOW, 8'h08);
    rdc(dsbb_pkg::ADDR_THR_HIGH, 8'h38);
    rdc(dsbb_pkg::ADDR_WAKE_EN, 8'h00);
    rdc(dsbb_pkg::ADDR_ANALOG, 8'h00);
    rdc(dsbb_pkg::ADDR_CHANNEL, 8'h00);
    rdc(6'h3a, 8'h00);
    rdc(dsbb_pkg::ADDR_WAKE_STAT, 8'h01);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_WAKE_EN, 8'h00);
    pd = 1'b1;
    rdc(dsbb_pkg::ADDR_WAKE_STAT, 8'h00);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_WAKE_STAT, 8'h01);
    rdc(dsbb_pkg::ADDR_WAKE_STAT, 8'h00);
    pd = 1'b0;
    repeat (dsbb_pkg::READY_CYC + 4) @(negedge i_clk);
    chk1(irq, 1'b0);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_WAKE_EN, 8'h01);
    chk1(irq, 1'b1);
    rdc(dsbb_pkg::ADDR_WAKE_STAT, 8'h01);
    chk1(irq, 1'b0);
    // Correlator decisions around both default thresholds
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 64; k++) begin
        @(negedge i_clk);
        rx_chip = CODE[k] ^ (k >= mt[i]);
        rx_chip_en = 1'b1;
        @(negedge i_clk);
        rx_chip_en = 1'b0;
        rx_chip = ~rx_chip;
      end
      repeat (3) @(negedge i_clk);
      chk8({6'h00, rx_valid, rx_bit}, mx[i]);
    end
    // Low 32-chip half: 30 matches against a lowered high threshold
    mode = 2'd1;
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_THR_HIGH, 8'h1c);
    for (int k = 0; k < 32; k++) begin
      @(negedge i_clk);
      rx_chip = CODE[k] ^ (k < 2);
      rx_chip_en = 1'b1;
      @(negedge i_clk);
      rx_chip_en = 1'b0;
    end
    repeat (3) @(negedge i_clk);
    mode = 2'd0;
    chk8({6'h00, rx_valid, rx_bit}, 8'h03);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_GAIN_CTL, 8'h80);
    chk8(gain, 8'h00);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_ANALOG, 8'h40);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_GAIN_CTL, 8'h80);
    chk8(gain, 8'h80);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_CARRIER, 8'h80);
    chk8(carrier, 8'h80);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_ANALOG, 8'h44);
    chk8({6'h00, amp_oe, amp_pin}, 8'h02);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_ANALOG, 8'h46);
    chk1(amp_pin, 1'b1);
    synth_count = 8'h3c;
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_CHANNEL, 8'h85);
    chk8(synth_word, 8'h3c);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_CHANNEL, 8'h05);
    chk8(synth_word, 8'h05);
    rssi = 5'h13;
    @(negedge i_clk);
    rx_enter = 1'b1;
    @(negedge i_clk);
    rx_enter = 1'b0;
    rssi = 5'h0c;
    chk8({2'b00, rssi_valid, rssi_sample}, 8'h33);
    // Preamble bit, then three data bits of 0xa5
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_TX_VALID, 8'h0e);
    tx_data = 8'ha5;
    @(negedge i_clk);
    tx_load = 1'b1;
    @(negedge i_clk);
    tx_load = 1'b0;
    n = 0;
    repeat (2400) begin
      @(negedge i_clk);
      if (tx_chip_en) begin
        b = n / 64;
        chk1(tx_is_data, b != 0);
        chk1(tx_chip, b == 0 ? CODE[n % 64] : CODE[n % 64] ^ ~tx_data[b]);
        if (n == 100) chk1(amp_pin, 1'b0);
        n++;
      end
      if (!tx_busy) break;
    end
    chk1(n == 256, 1'b1);
    chk1(amp_pin, 1'b1);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_THR_LOW, 8'h7f);
    rdc(dsbb_pkg::ADDR_THR_LOW, 8'h7f);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_ANALOG, 8'h01);
    rdc(dsbb_pkg::ADDR_THR_LOW, 8'h08);
    rdc(dsbb_pkg::ADDR_ANALOG, 8'h00);
    chk8({gain[7], amp_oe, use_cnt, id_en, rssi_valid}, 8'h00);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_ANALOG, 8'h20);
    chk1(id_en, 1'b1);
    dsbb_host_model_i.wr(dsbb_pkg::ADDR_ANALOG, 8'h00);
    chk1(id_en, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
